// file: src/scr_core.sv
`timescale 1ns/1ps
// Contract
// - non-memory instruction completes in one cycle
// - memory instruction takes two cycles
// - call one cycle, return merged free
// - top loaded via alu output, literal, register read, peripheral read, pop or product
// - top/next hold 32-bit product halves
// - push moves next to stack, top to next
// - memory data passes through next register
// - latch holds instruction, supplies short literal
// - config access suppresses interrupts one cycle
// - program counter cleared by reset
// - index holds return top, count, writable
// - index push/pop or read/write by address
// - streamed mode repeats next instruction count+1
// - divide register holds divisor or scratch
// - root register holds intermediates or scratch
// - counts decrement each rising timing edge, reads harmless
// - zero count reloads preload next edge
// - preload write loads count next cycle
// - product high holds upper or rounded product
// - product low holds lower product bits
// - extension holds accumulator top, shift count
// - 19-bit memory, 3-bit peripheral address, two data buses
// - processor clock is input clock halved
// - wait holds processor clock low, extends
module scr_core
   import scr_pkg::*;
#(
   parameter int STACK_DEPTH = 256
) (
   input  wire logic                i_ref_clk,
   input  wire logic                i_reset,
   input  wire logic                i_wait,
   input  wire logic                i_int_suppress,
   input  wire logic [SCR_DW-1:0]   i_memory_data_bus,
   output logic      [SCR_DW-1:0]   o_memory_data_bus,
   output logic                     o_memory_data_oe,
   output logic      [SCR_MAW-1:0]  o_memory_address_bus,
   output logic                     o_memory_rd_n_wr,
   input  wire logic [SCR_DW-1:0]   i_peripheral_data_bus,
   output logic      [SCR_DW-1:0]   o_peripheral_data_bus,
   output logic                     o_peripheral_data_oe,
   output logic      [SCR_GAW-1:0]  o_peripheral_address_bus,
   output logic                     o_peripheral_io_n,
   output logic                     o_peripheral_rd_n_wr,
   output logic                     o_pclk,
   output logic                     o_timing_clock,
   output logic                     o_int_blocked
);
   localparam int SPW = $clog2(STACK_DEPTH);

   // stack pointers wrap, so depth must be a power of two
   if (STACK_DEPTH < 2 || STACK_DEPTH > 256 || 2 ** SPW != STACK_DEPTH) begin : g_bad_depth
      $error("stack depth out of range");
   end

   typedef struct packed {
      logic [SCR_DW-1:0]  top;
      logic [SCR_DW-1:0]  next;
      logic [SCR_DW-1:0]  latch;
      logic [SCR_DW-1:0]  cfg;
      logic [SCR_DW-1:0]  pc;
      logic [SCR_DW-1:0]  idx;
      logic [4:0]         ipe;
      logic [SCR_DW-1:0]  divr;
      logic [SCR_DW-1:0]  root;
      logic [SCR_DW-1:0]  interrupt_base_control;
      logic [SCR_DW-1:0]  prod_hi;
      logic [SCR_DW-1:0]  prod_lo;
      logic [SCR_DW-1:0]  acc_ext;
      logic               second;   // in data cycle of memory instruction
      logic               stream;   // streamed instruction active
      logic               int_blk;
      logic [SPW-1:0]     psp;
      logic [SPW-1:0]     rsp;
      scr_mem_t           mem;
   } scr_core_t;

   scr_core_t s_q;
   scr_core_t s_d;

   logic [SCR_DW-1:0] pstack_q [STACK_DEPTH];
   logic [20:0]       rstack_q [STACK_DEPTH];
   logic              cycle_en;
   logic              tick_en;
   logic              tmr_load [3];
   logic [SCR_DW-1:0] tmr_count [3];

   // processor and timing clocks
   scr_clkdiv u_div (
      .i_ref_clk  (i_ref_clk),
      .i_reset    (i_reset),
      .i_wait     (i_wait),
      .o_pclk     (o_pclk),
      .o_timing_clock     (o_timing_clock),
      .o_cycle_en (cycle_en),
      .o_tick_en  (tick_en)
   );

   // three timer/counters
   for (genvar g = 0; g < 3; g++) begin : g_tmr
      assign tmr_load[g] = cycle_en && !s_q.second && s_q.latch[15:12] == SCR_OP_WRREG
                           && s_q.latch[4:0] == SCR_A_TMR0 + 5'(g);
      scr_timer #(.WIDTH(SCR_DW)) u_tmr (
         .i_ref_clk (i_ref_clk),
         .i_reset   (i_reset),
         .i_tick_en (tick_en),
         .i_load    (tmr_load[g]),
         .i_preload (s_q.top),
         .o_count   (tmr_count[g])
      );
   end

   // opcode and operands of executing instruction
   scr_op_t            op;
   logic [4:0]         ra;
   logic [SCR_DW-1:0]  rd_val;
   logic [SCR_DW-1:0]  alu;
   logic [31:0]        prod;
   logic [32:0]        accum;
   logic [SCR_DW-1:0]  pop_val;
   logic [20:0]        rpop_val;

   assign op       = scr_op_t'(s_q.latch[SCR_OP_HI:SCR_OP_LO]);
   assign ra       = s_q.latch[4:0];
   assign pop_val  = pstack_q[s_q.psp - SPW'(1)];
   assign rpop_val = rstack_q[s_q.rsp - SPW'(1)];
   assign prod     = 32'(s_q.top) * 32'(s_q.next);
   assign accum    = {1'b0, s_q.prod_hi, s_q.prod_lo} + {1'b0, prod};  // carry into ext

   // explicit register read mux
   always_comb begin
      rd_val = SCR_RST_ZERO;
      unique case (ra)
         SCR_A_IDX_POP, SCR_A_IDX_RW: rd_val = s_q.idx;
         SCR_A_CFG:      rd_val = s_q.cfg;
         SCR_A_DIV:      rd_val = s_q.divr;
         SCR_A_ROOT:     rd_val = s_q.root;
         SCR_A_PC:       rd_val = s_q.pc;
         SCR_A_IPE:      rd_val = {11'h000, s_q.ipe};
         SCR_A_IBC:      rd_val = s_q.interrupt_base_control;
         SCR_A_ACC_EXT:  rd_val = s_q.acc_ext;
         5'h13:          rd_val = tmr_count[0];
         5'h14:          rd_val = tmr_count[1];
         5'h15:          rd_val = tmr_count[2];
         SCR_A_PROD_LO:  rd_val = s_q.prod_lo;
         SCR_A_PROD_HI:  rd_val = s_q.prod_hi;
         default:        rd_val = SCR_RST_ZERO;
      endcase
   end

   // alu: top receives this value on an alu instruction
   always_comb begin
      unique case (s_q.latch[11:8])
         4'h0:    alu = s_q.top;
         4'h1:    alu = s_q.top & s_q.next;
         4'h2:    alu = s_q.top | s_q.next;
         4'h3:    alu = s_q.top ^ s_q.next;
         4'h4:    alu = s_q.next + s_q.top;
         4'h5:    alu = s_q.next - s_q.top;
         4'h6:    alu = ~s_q.top;
         4'h7:    alu = {s_q.top[14:0], 1'b0};
         default: alu = s_q.top;
      endcase
   end

   // next-state of the core
   always_comb begin
      s_d = s_q;
      if (cycle_en) begin
         s_d.int_blk = 1'b0;
         if (s_q.second) begin
            // second cycle: read data into next and fetch of the following instruction
            s_d.second  = 1'b0;
            if (s_q.mem.rd_n_wr) begin
               s_d.next = i_memory_data_bus;
            end
            // next instruction already latched; fetch its successor
            s_d.mem.addr = 19'(s_q.pc);
            s_d.mem.oe   = 1'b0;
            s_d.mem.rd_n_wr = 1'b1;
         end else begin
            // fetch overlaps execute: latch next instruction
            s_d.latch    = i_memory_data_bus;
            s_d.pc       = s_q.pc + 16'h0002;
            s_d.mem.addr = 19'(s_q.pc + 16'h0002);
            unique case (op)
               SCR_OP_ALU: begin
                  s_d.top = alu;
               end
               SCR_OP_LIT: begin
                  s_d.psp  = s_q.psp + SPW'(1);
                  s_d.next = s_q.top;
                  s_d.top  = {8'h00, s_q.latch[7:0]};
               end
               SCR_OP_LOAD, SCR_OP_STORE: begin
                  // data cycle next: address out, data through next
                  // fetched instruction is latched now and runs after it
                  s_d.second      = 1'b1;
                  s_d.mem.addr    = 19'(s_q.top);
                  s_d.mem.oe      = op == SCR_OP_STORE;
                  s_d.mem.rd_n_wr = op != SCR_OP_STORE;
                  s_d.mem.wdata   = s_q.next;
               end
               SCR_OP_RDREG: begin
                  s_d.psp  = s_q.psp + SPW'(1);
                  s_d.next = s_q.top;
                  s_d.top  = rd_val;
                  if (ra == SCR_A_CFG) s_d.int_blk = 1'b1;
                  if (ra == SCR_A_IDX_POP) begin
                     s_d.idx = rpop_val[15:0];
                     s_d.ipe = rpop_val[20:16];
                     s_d.rsp = s_q.rsp - SPW'(1);
                  end
               end
               SCR_OP_WRREG: begin
                  // write lands now, seen by next instruction
                  s_d.top = s_q.next;
                  s_d.next = pop_val;
                  s_d.psp  = s_q.psp - SPW'(1);
                  unique case (ra)
                     SCR_A_IDX_POP: begin
                        s_d.idx = s_q.top;
                        s_d.ipe = s_q.pc[15:11];
                        s_d.rsp = s_q.rsp + SPW'(1);
                     end
                     SCR_A_IDX_RW:  s_d.idx = s_q.top;
                     SCR_A_CFG: begin
                        s_d.cfg     = s_q.top;
                        s_d.int_blk = 1'b1;
                     end
                     SCR_A_DIV:     s_d.divr    = s_q.top;
                     SCR_A_ROOT:    s_d.root    = s_q.top;
                     SCR_A_PC:      s_d.pc      = s_q.top;
                     SCR_A_IPE:     s_d.ipe     = s_q.top[4:0];
                     SCR_A_IBC:     s_d.interrupt_base_control     = s_q.top;
                     SCR_A_ACC_EXT: s_d.acc_ext = s_q.top;  // shift count
                     SCR_A_PROD_LO: s_d.prod_lo = s_q.top;
                     SCR_A_PROD_HI: s_d.prod_hi = s_q.top;
                     default: ;
                  endcase
               end
               SCR_OP_IORD: begin
                  s_d.psp  = s_q.psp + SPW'(1);
                  s_d.next = s_q.top;
                  s_d.top  = i_peripheral_data_bus;
               end
               SCR_OP_IOWR: begin
                  // top goes out on the peripheral bus, then pops
                  s_d.top  = s_q.next;
                  s_d.next = pop_val;
                  s_d.psp  = s_q.psp - SPW'(1);
               end
               SCR_OP_STREAM: begin
                  s_d.idx    = s_q.top;
                  s_d.stream = 1'b1;
                  s_d.top    = s_q.next;
                  s_d.next   = pop_val;
                  s_d.psp    = s_q.psp - SPW'(1);
               end
               SCR_OP_MUL: begin
                  if (s_q.latch[0]) begin
                     // accumulate: ext, middle, low words
                     s_d.acc_ext = 16'(accum[32:32]) + s_q.acc_ext;
                     {s_d.prod_hi, s_d.prod_lo} = accum[31:0];
                  end else begin
                     s_d.prod_lo = prod[15:0];
                     s_d.prod_hi = s_q.interrupt_base_control[SCR_IBC_ROUND_BIT] ?
                                   prod[31:16] + 16'(prod[15]) : prod[31:16];
                     s_d.top     = prod[31:16];
                     s_d.next    = prod[15:0];
                  end
               end
               default: begin
                  // call: one cycle, return address onto return stack
                  s_d.idx      = s_q.pc;
                  s_d.ipe      = 5'h00;
                  s_d.rsp      = s_q.rsp + SPW'(1);
                  s_d.pc       = {3'b000, s_q.latch[11:0], 1'b0};
                  s_d.mem.addr = 19'({3'b000, s_q.latch[11:0], 1'b0});
               end
            endcase
            // return bit merged into alu instruction
            if (op == SCR_OP_ALU && s_q.latch[5]) begin
               s_d.pc       = s_q.idx;
               s_d.mem.addr = 19'(s_q.idx);
               s_d.idx      = rpop_val[15:0];
               s_d.ipe      = rpop_val[20:16];
               s_d.rsp      = s_q.rsp - SPW'(1);
            end
            // streamed: hold latch on same instruction count times, so it runs count+1 times
            if (s_q.stream) begin
               if (s_q.idx == 16'h0000) begin
                  s_d.stream = 1'b0;
               end else begin
                  s_d.idx      = s_q.idx - 16'h0001;
                  s_d.latch    = s_q.latch;
                  s_d.pc       = s_q.pc;
                  s_d.mem.addr = s_q.mem.addr;
               end
            end
         end
      end
   end

   // state register; program counter cleared at reset
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_q         <= '0;
         s_q.top     <= SCR_RST_TOP;
         s_q.next    <= SCR_RST_NEXT;
         s_q.cfg     <= SCR_RST_CFG;
         s_q.pc      <= SCR_RST_PC;
         s_q.idx     <= SCR_RST_IDX;
         s_q.divr    <= SCR_RST_DIV;
         s_q.root    <= SCR_RST_ROOT;
         s_q.mem.rd_n_wr <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // stack memories: next goes to parameter stack on push
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset && s_d.psp == s_q.psp + SPW'(1)) begin
         pstack_q[s_q.psp] <= s_q.next;
      end
      if (!i_reset && s_d.rsp == s_q.rsp + SPW'(1)) begin
         rstack_q[s_q.rsp] <= {s_q.ipe, s_q.idx};
      end
   end

   // bus outputs
   assign o_memory_address_bus     = s_q.mem.addr;
   assign o_memory_data_bus        = s_q.mem.wdata;
   assign o_memory_data_oe         = s_q.mem.oe;
   assign o_memory_rd_n_wr         = s_q.mem.rd_n_wr;
   assign o_peripheral_address_bus = s_q.latch[2:0];
   assign o_peripheral_data_bus    = s_q.top;             // top to any device
   // latch holds the following instruction in a data cycle: keep peripheral bus idle
   assign o_peripheral_data_oe     = op == SCR_OP_IOWR && !s_q.second;
   assign o_peripheral_io_n        = !((op == SCR_OP_IOWR || op == SCR_OP_IORD) && !s_q.second);
   assign o_peripheral_rd_n_wr     = !(op == SCR_OP_IOWR && !s_q.second);
   assign o_int_blocked            = s_q.int_blk | i_int_suppress;
endmodule

// file: src/scr_pkg.sv
package scr_pkg;

   // widths
   localparam int SCR_DW  = 16;
   localparam int SCR_MAW = 19;
   localparam int SCR_GAW = 3;

   // register bus addresses of the on-chip registers (5-bit peripheral space)
   localparam logic [4:0] SCR_A_IDX_POP  = 5'h00; // index, push/pop access
   localparam logic [4:0] SCR_A_IDX_RW   = 5'h01; // index, read/write access
   localparam logic [4:0] SCR_A_CFG      = 5'h03;
   localparam logic [4:0] SCR_A_DIV      = 5'h04;
   localparam logic [4:0] SCR_A_ROOT     = 5'h06;
   localparam logic [4:0] SCR_A_PC       = 5'h07;
   localparam logic [4:0] SCR_A_IPE      = 5'h0C;
   localparam logic [4:0] SCR_A_IBC      = 5'h10;
   localparam logic [4:0] SCR_A_ACC_EXT  = 5'h12;
   localparam logic [4:0] SCR_A_TMR0     = 5'h13;
   localparam logic [4:0] SCR_A_PROD_LO  = 5'h16;
   localparam logic [4:0] SCR_A_PROD_HI  = 5'h17;

   // reset values
   localparam logic [15:0] SCR_RST_TOP  = 16'h0000;
   localparam logic [15:0] SCR_RST_NEXT = 16'hFFFF;
   localparam logic [15:0] SCR_RST_IDX  = 16'hFFFF;
   localparam logic [15:0] SCR_RST_CFG  = 16'h4008;
   localparam logic [15:0] SCR_RST_DIV  = 16'hFFFF;
   localparam logic [15:0] SCR_RST_ROOT = 16'h0200;
   localparam logic [15:0] SCR_RST_PC   = 16'h0000;
   localparam logic [15:0] SCR_RST_ZERO = 16'h0000;

   // field positions
   localparam int SCR_IBC_ROUND_BIT = 8;   // rounding control in interrupt base control
   localparam int SCR_CFG_BOOT_BIT  = 3;

   // instruction field positions (simplified opcode map)
   localparam int SCR_OP_HI = 15;
   localparam int SCR_OP_LO = 12;

   // operation classes of the executing instruction
   typedef enum logic [3:0] {
      SCR_OP_ALU   = 4'h0, // single-cycle alu, opt. return in bit 5
      SCR_OP_LIT   = 4'h1, // short literal from low 8 bits
      SCR_OP_LOAD  = 4'h2, // mem read to next, address top
      SCR_OP_STORE = 4'h3, // mem write of next, address top
      SCR_OP_RDREG = 4'h4, // push register (addr bits 4:0)
      SCR_OP_WRREG = 4'h5, // write top to register, pop
      SCR_OP_IORD  = 4'h6, // peripheral read into top
      SCR_OP_IOWR  = 4'h7, // peripheral write of top
      SCR_OP_STREAM= 4'h8, // write count, stream next instruction
      SCR_OP_MUL   = 4'h9, // multiply-accumulate step
      SCR_OP_CALL  = 4'hA  // others: call, target in bits 11:0 (word)
   } scr_op_t;

   // processor clock phase state
   typedef enum logic [1:0] {SCR_PH_HI, SCR_PH_LO, SCR_PH_WAIT} scr_phase_t;

   // memory bus bundle
   typedef struct packed {
      logic [SCR_MAW-1:0] addr;
      logic [SCR_DW-1:0]  wdata;
      logic               oe;
      logic               rd_n_wr;
   } scr_mem_t;

endpackage

// file: src/scr_clkdiv.sv
`timescale 1ns/1ps
// divides the input clock by two into processor and timing enables
module scr_clkdiv
   import scr_pkg::*;
(
   input  wire logic i_ref_clk,
   input  wire logic i_reset,
   input  wire logic i_wait,
   output logic      o_pclk,
   output logic      o_timing_clock,
   output logic      o_cycle_en,
   output logic      o_tick_en
);
   typedef struct packed {
      logic timing_clock;
      logic pclk;
   } scr_div_t;

   scr_div_t s_q;
   scr_div_t s_d;

   // timing clock toggles freely, processor clock held low in wait
   always_comb begin
      s_d      = s_q;
      s_d.timing_clock = ~s_q.timing_clock;
      s_d.pclk = ~s_q.timing_clock & ~i_wait;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_pclk     = s_q.pclk;
   assign o_timing_clock     = s_q.timing_clock;
   assign o_cycle_en = s_q.pclk & s_q.timing_clock;   // last half of a processor cycle
   assign o_tick_en  = ~s_q.timing_clock;             // rising timing edge next
endmodule

// file: src/scr_timer.sv
`timescale 1ns/1ps
// one down counter with write-only preload
module scr_timer
   import scr_pkg::*;
#(
   parameter int WIDTH = SCR_DW
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset,
   input  wire logic             i_tick_en,
   input  wire logic             i_load,
   input  wire logic [WIDTH-1:0] i_preload,
   output logic      [WIDTH-1:0] o_count
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] preload;
      logic             load_pend;
   } scr_tmr_t;

   scr_tmr_t s_q;
   scr_tmr_t s_d;

   if (WIDTH < 1) begin : g_bad_width
      $error("scr_timer width must be positive");
   end

   // decrement on timing edge; reload at zero; preload write next cycle
   always_comb begin
      s_d = s_q;
      if (i_load) begin
         s_d.preload   = i_preload;
         s_d.load_pend = 1'b1;
      end
      if (s_q.load_pend) begin
         s_d.count     = s_q.preload;
         s_d.load_pend = i_load;
      end else if (i_tick_en) begin
         if (s_q.count == '0) begin
            s_d.count = s_q.preload;
         end else begin
            s_d.count = s_q.count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_count = s_q.count;  // read never alters count
endmodule

// file: bench/scr_core_sva.sv
`timescale 1ns/1ps
// port checks on clocking, wait and bus timing of the core
module scr_core_sva
   import scr_pkg::*;
(
   input wire logic               i_ref_clk,
   input wire logic               i_reset,
   input wire logic               i_wait,
   input wire logic               i_int_suppress,
   input wire logic [SCR_MAW-1:0] o_memory_address_bus,
   input wire logic               o_memory_data_oe,
   input wire logic               o_memory_rd_n_wr,
   input wire logic               o_pclk,
   input wire logic               o_timing_clock,
   input wire logic               o_int_blocked
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // reset levels, clock division, wait and bus holding
   a_reset_level: assert property (
      $fell(i_reset) |-> o_memory_address_bus == '0 && !o_memory_data_oe && !o_pclk)
      else $error("outputs not at reset level");
   a_pclk_half: assert property (o_pclk |=> !o_pclk)
      else $error("pclk high two cycles");
   a_timing_clock_half: assert property (o_timing_clock |=> !o_timing_clock)
      else $error("timing_clock high two cycles");
   a_timing_clock_runs: assert property (!o_timing_clock |-> ##[1:2] o_timing_clock)
      else $error("timing_clock stopped");
   a_wait_holds: assert property (i_wait [*2] |-> !o_pclk)
      else $error("pclk high in wait");
   a_pclk_phase: assert property (o_pclk |-> o_timing_clock)
      else $error("pclk out of phase");
   a_addr_stands: assert property (
      $changed(o_memory_address_bus) |=> $stable(o_memory_address_bus))
      else $error("address changed within a cycle");
   a_write_dir: assert property (o_memory_data_oe |-> !o_memory_rd_n_wr)
      else $error("data driven while reading");
   a_int_block: assert property (i_int_suppress [*2] |-> o_int_blocked)
      else $error("interrupts not blocked");
   c_wait: cover property (i_wait [*2] ##1 o_pclk);
   c_write: cover property (o_memory_data_oe && o_pclk);
   c_block: cover property (i_int_suppress [*2] ##1 o_int_blocked);
endmodule

bind scr_core scr_core_sva i_sva (.i_ref_clk, .i_reset, .i_wait, .i_int_suppress,
   .o_memory_address_bus, .o_memory_data_oe, .o_memory_rd_n_wr, .o_pclk, .o_timing_clock,
   .o_int_blocked);

// file: bench/scr_mem_model.sv
`timescale 1ns/1ps
// memory and peripheral stand-in: program store and a log of writes
module scr_mem_model
   import scr_pkg::*;
(
   input  wire logic               i_ref_clk,
   input  wire logic               i_pclk,
   input  wire logic [SCR_MAW-1:0] i_addr,
   input  wire logic               i_rd_n_wr,
   input  wire logic               i_oe,
   input  wire logic [SCR_DW-1:0]  i_wdata,
   input  wire logic               i_per_oe,
   input  wire logic [SCR_DW-1:0]  i_per_wdata,
   output logic      [SCR_DW-1:0]  o_rdata,
   output logic      [SCR_DW-1:0]  o_per_rdata
);
   logic [SCR_DW-1:0] prog [256];
   logic [SCR_DW-1:0] wr_log [$];
   logic [SCR_DW-1:0] per_log [$];
   logic [SCR_DW-1:0] last_q = 16'h0000;
   logic [SCR_DW-1:0] per_q  = 16'h0000;
   // bus level: device drive, program word, or a changing idle pattern
   always_comb begin
      o_rdata = ~last_q;
      if (i_oe)
         o_rdata = i_wdata;
      else if (i_rd_n_wr)
         o_rdata = prog[i_addr[8:1]];
      o_per_rdata = i_per_oe ? i_per_wdata : ~per_q;
   end
   // remember bus levels, log one write per processor cycle
   always @(posedge i_ref_clk) begin
      last_q <= o_rdata;
      per_q <= o_per_rdata;
      if (i_pclk && i_oe && !i_rd_n_wr)
         wr_log.push_back(i_wdata);
      if (i_pclk && i_per_oe)
         per_log.push_back(i_per_wdata);
   end
endmodule

// file: bench/stack_cpu_core_registers_bench.sv
`timescale 1ns/1ps
// core bench: reset, clocking, wait, register round trips seen as stores
module stack_cpu_core_registers_bench;
   import scr_pkg::*;
   logic               i_ref_clk, i_reset, i_wait, i_int_suppress;
   logic [SCR_DW-1:0]  i_memory_data_bus, o_memory_data_bus;
   logic [SCR_DW-1:0]  i_peripheral_data_bus, o_peripheral_data_bus;
   logic [SCR_MAW-1:0] o_memory_address_bus;
   logic [SCR_GAW-1:0] o_peripheral_address_bus;
   logic               o_memory_data_oe, o_memory_rd_n_wr, o_peripheral_data_oe;
   logic               o_peripheral_io_n, o_peripheral_rd_n_wr, o_pclk, o_timing_clock;
   logic               o_int_blocked;
   logic [SCR_DW-1:0]  exp_q [$];
   logic [SCR_DW-1:0]  tv;
   int                 bad_count, tests_run, pc_n, np, nt, blk_n;
   localparam logic [4:0] RG [6] = '{SCR_A_DIV, SCR_A_ROOT, SCR_A_IDX_RW,
                                     SCR_A_PROD_LO, SCR_A_PROD_HI, SCR_A_ACC_EXT};
   localparam logic [7:0] VL [6] = '{8'h5A, 8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h42};

   // 100 MHz reference clock
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   scr_core i_dut (.i_ref_clk, .i_reset, .i_wait, .i_int_suppress, .i_memory_data_bus,
      .o_memory_data_bus, .o_memory_data_oe, .o_memory_address_bus, .o_memory_rd_n_wr,
      .i_peripheral_data_bus, .o_peripheral_data_bus, .o_peripheral_data_oe,
      .o_peripheral_address_bus, .o_peripheral_io_n, .o_peripheral_rd_n_wr, .o_pclk,
      .o_timing_clock, .o_int_blocked);
   scr_mem_model i_mem (.i_ref_clk, .i_pclk(o_pclk), .i_addr(o_memory_address_bus),
      .i_rd_n_wr(o_memory_rd_n_wr), .i_oe(o_memory_data_oe), .i_wdata(o_memory_data_bus),
      .i_per_oe(o_peripheral_data_oe), .i_per_wdata(o_peripheral_data_bus),
      .o_rdata(i_memory_data_bus), .o_per_rdata(i_peripheral_data_bus));

   // ref cycles blocked by a config access alone
   always @(posedge i_ref_clk)
      if (o_int_blocked && !i_int_suppress)
         blk_n++;

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc();
      @(posedge i_ref_clk);
      #1;
   endtask
   task automatic count8(output int p, output int t);
      p = 0;
      t = 0;
      repeat (8) begin
         cyc();
         p += int'(o_pclk);
         t += int'(o_timing_clock);
      end
   endtask
   // program builders: a word, a register write, a register read stored out
   task automatic put(input logic [15:0] w);
      i_mem.prog[pc_n] = w;
      pc_n++;
   endtask
   task automatic wr(input logic [4:0] r, input logic [7:0] v);
      put({SCR_OP_LIT, 4'h0, v});
      put({SCR_OP_WRREG, 7'h00, r});
   endtask
   task automatic emit(input logic [4:0] r, input logic [15:0] e);
      put({SCR_OP_RDREG, 7'h00, r});
      put({SCR_OP_LIT, 4'h0, 8'hF0});
      put({SCR_OP_STORE, 12'h000});
      exp_q.push_back(e);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      i_reset = 1'b1;
      i_wait = 1'b0;
      i_int_suppress = 1'b0;
      bad_count = 0;
      tests_run = 0;
      pc_n = 0;
      for (int k = 0; k < 256; k++)
         i_mem.prog[k] = {SCR_OP_LIT, 12'h000};
      emit(SCR_A_CFG, SCR_RST_CFG);
      emit(5'h1F, SCR_RST_ZERO);
      for (int k = 0; k < 6; k++) begin
         wr(RG[k], VL[k]);
         emit(RG[k], {8'h00, VL[k]});
      end
      wr(SCR_A_IDX_POP, 8'h11);
      wr(SCR_A_IDX_POP, 8'h22);
      emit(SCR_A_IDX_POP, 16'h0022);
      emit(SCR_A_IDX_RW, 16'h0011);
      emit(SCR_A_IDX_POP, 16'h0011);
      emit(SCR_A_IDX_RW, 16'h003C);
      put({SCR_OP_LIT, 4'h0, 8'h5A});
      put({SCR_OP_IOWR, 12'h005});
      wr(SCR_A_TMR0, 8'hC8);
      emit(SCR_A_TMR0, 16'h0000);
      void'(exp_q.pop_back());
      repeat (16) @(posedge i_ref_clk);
      #1;
      i_reset = 1'b0;
      chk("address", 16'h0000, o_memory_address_bus[15:0]);
      chk("data enable", 16'h0000, {15'h0000, o_memory_data_oe});
      $display("test reset done");
      count8(np, nt);
      chk("pclk highs", 16'h0004, np[15:0]);
      chk("timing_clock highs", 16'h0004, nt[15:0]);
      i_wait = 1'b1;
      cyc();
      count8(np, nt);
      i_wait = 1'b0;
      chk("pclk highs in wait", 16'h0000, np[15:0]);
      chk("timing_clock highs in wait", 16'h0004, nt[15:0]);
      $display("test clocks done");
      i_int_suppress = 1'b1;
      repeat (3) cyc();
      chk("interrupt block", 16'h0001, {15'h0000, o_int_blocked});
      i_int_suppress = 1'b0;
      $display("test suppress done");
      for (int n = 0; n < 4000 && i_mem.wr_log.size() <= exp_q.size(); n++)
         cyc();
      foreach (exp_q[k])
         chk("stored register", exp_q[k], i_mem.wr_log[k]);
      tv = i_mem.wr_log[exp_q.size()];
      chk("timer range", 16'h0001, {15'h0000, tv <= 16'h00C8 && tv >= 16'h00B0});
      chk("peripheral write", 16'h005A, i_mem.per_log[0]);
      chk("config block cycles", 16'h0002, blk_n[15:0]);
      $display("test registers done");
      close_out();
   end

   // cut a hung run short
   initial begin
      #100000;
      bad_count++;
      close_out();
   end
endmodule
